// ### hw/cbsc_seq.v
// bus sequencer for locked, acknowledge and special cycles
`timescale 1ns/1ps
`include "cbsc_map.vh"
module cbsc_seq (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_ce,
   input wire i_bus_backoff_n,
   input wire i_burst_ready_n,
   input wire i_maskable_irq_req,
   input wire i_stop_clock_req_n,
   input wire i_ext_write_buf_empty_n,
   input wire i_sys_mgmt_irq_n,
   input wire i_nmi,
   input wire i_soft_init,
   input wire i_cache_flush_n,
   input wire i_instr_boundary,
   input wire i_locked_wr_req,
   input wire i_modified_hit,
   input wire i_cache_wb_done,
   input wire i_writeback_invalidate_instr,
   input wire i_invalidate_instr,
   input wire i_halt_instr,
   input wire i_triple_fault,
   input wire [7:0] i_data_lo,
   output reg o_addr_strobe_n,
   output reg o_lock_n,
   output reg o_bus_oe,
   output reg o_dc_n,
   output reg o_mio_n,
   output reg o_wr_n,
   output reg [7:0] o_byte_enables_n,
   output reg [28:0] o_addr,
   output reg o_cache_wb_req,
   output reg o_cache_inval_req,
   output reg o_vector_valid,
   output reg [7:0] o_vector,
   output reg o_locked_wr_done,
   output reg o_int_clk_stopped,
   output reg o_shutdown,
   output reg o_soft_init_done,
   output reg [31:0] o_fetch_addr
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam ST_IDLE = 4'h0; // bus idle
   localparam ST_LKWR = 4'h1; // locked write in flight
   localparam ST_HOLD = 4'h2; // backed off, bus floated
   localparam ST_WBK = 4'h3; // locked writeback after hit
   localparam ST_ACK1 = 4'h4; // dummy acknowledge read
   localparam ST_ACK2 = 4'h5; // vector acknowledge read
   localparam ST_CWB = 4'h6; // waiting on cache writeback
   localparam ST_SPC = 4'h7; // special cycle in flight
   localparam ST_GNT = 4'h8; // stop grant, internal clock off once buffers drain
   localparam ST_SHUT = 4'h9; // shutdown
   reg [3:0] state_reg, state_next;
   reg [3:0] resume_reg, resume_next; // where a backoff returns
   reg [2:0] op_reg, op_next; // pending special cycle
   reg [2:0] after_reg, after_next; // second special after wb
   reg strobe_reg; // first cycle of a transfer shows strobe
   reg strobe_next;
   wire [7:0] spc_be_n; // enables for op_next, ready at the strobe edge
   wire [1:0] spc_a43;
   wire bus_backoff_n = ~i_bus_backoff_n;
   wire burst_ready_n = ~i_burst_ready_n;

   cbsc_decode u_dec (
      .i_op(op_next),
      .o_be_n(spc_be_n),
      .o_a43(spc_a43)
   );

   // ------------------------------------------------------------
   // next state; backoff checked first so it always wins
   // ------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      resume_next = resume_reg;
      op_next = op_reg;
      after_next = after_reg;
      strobe_next = 1'b0;
      if (bus_backoff_n && state_reg != ST_IDLE && state_reg != ST_GNT &&
          state_reg != ST_SHUT && state_reg != ST_CWB &&
          state_reg != ST_HOLD) begin
         // abort even when burst ready arrives on this edge
         // a writeback cut short keeps the cycle it was in front of
         resume_next = (state_reg == ST_WBK) ? resume_reg : state_reg;
         state_next = ST_HOLD;
      end else begin
         case (state_reg)
            ST_IDLE: if (!bus_backoff_n) begin // bus held off: take nothing
               if (i_triple_fault) begin
                  op_next = `CBSC_OP_SHUTDN;
                  state_next = ST_SPC;
                  strobe_next = 1'b1;
               end else if (!i_cache_flush_n) begin
                  op_next = `CBSC_OP_FLUSHACK;
                  after_next = `CBSC_OP_NONE;
                  state_next = ST_CWB;
               end else if (i_instr_boundary && i_soft_init) begin
                  state_next = ST_IDLE; // handled in outputs
               end else if (i_instr_boundary && !i_stop_clock_req_n) begin
                  op_next = `CBSC_OP_STOPGNT;
                  state_next = ST_SPC;
                  strobe_next = 1'b1;
               end else if (i_instr_boundary && i_maskable_irq_req) begin
                  state_next = ST_ACK1;
                  strobe_next = 1'b1;
               end else if (i_writeback_invalidate_instr) begin
                  op_next = `CBSC_OP_WRBACK;
                  after_next = `CBSC_OP_FLUSH;
                  state_next = ST_CWB;
               end else if (i_invalidate_instr) begin
                  op_next = `CBSC_OP_FLUSH;
                  state_next = ST_SPC;
                  strobe_next = 1'b1;
               end else if (i_halt_instr) begin
                  op_next = `CBSC_OP_HALT;
                  state_next = ST_SPC;
                  strobe_next = 1'b1;
               end else if (i_locked_wr_req) begin
                  state_next = ST_LKWR;
                  strobe_next = 1'b1;
               end
            end
            ST_HOLD: begin
               if (!bus_backoff_n) begin
                  // writeback of a modified hit goes before restart
                  state_next = i_modified_hit ? ST_WBK : resume_reg;
                  strobe_next = 1'b1;
               end
            end
            ST_WBK: if (burst_ready_n) begin
               state_next = resume_reg;
               strobe_next = 1'b1;
            end
            ST_LKWR: if (burst_ready_n) state_next = ST_IDLE;
            ST_ACK1: if (burst_ready_n) begin
               state_next = ST_ACK2;
               strobe_next = 1'b1;
            end
            ST_ACK2: if (burst_ready_n) state_next = ST_IDLE;
            ST_CWB: if (i_cache_wb_done) begin
               if (bus_backoff_n) begin
                  // bus held: the pending special cycle waits for release
                  resume_next = ST_SPC;
                  state_next = ST_HOLD;
               end else begin
                  state_next = ST_SPC;
                  strobe_next = 1'b1;
               end
            end
            ST_SPC: if (burst_ready_n) begin
               if (op_reg == `CBSC_OP_SHUTDN) begin
                  state_next = ST_SHUT;
               end else if (op_reg == `CBSC_OP_STOPGNT) begin
                  state_next = ST_GNT;
               end else if (after_reg != `CBSC_OP_NONE) begin
                  op_next = after_reg;
                  after_next = `CBSC_OP_NONE;
                  strobe_next = 1'b1;
               end else begin
                  state_next = ST_IDLE;
               end
            end
            ST_GNT: if (i_stop_clock_req_n) state_next = ST_IDLE;
            ST_SHUT: begin
               if (i_nmi || i_soft_init || !i_sys_mgmt_irq_n)
                  state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers; every output is a flip-flop
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         resume_reg <= ST_IDLE;
         op_reg <= `CBSC_OP_NONE;
         after_reg <= `CBSC_OP_NONE;
         strobe_reg <= 1'b0;
         o_addr_strobe_n <= 1'b1;
         o_lock_n <= 1'b1;
         o_bus_oe <= 1'b0;
         o_dc_n <= 1'b0;
         o_mio_n <= 1'b0;
         o_wr_n <= 1'b0;
         o_byte_enables_n <= `CBSC_BE_IDLE;
         o_addr <= `CBSC_ADDR_ZERO;
         o_cache_wb_req <= 1'b0;
         o_cache_inval_req <= 1'b0;
         o_vector_valid <= 1'b0;
         o_vector <= 8'h00;
         o_locked_wr_done <= 1'b0;
         o_int_clk_stopped <= 1'b0;
         o_shutdown <= 1'b0;
         o_soft_init_done <= 1'b0;
         o_fetch_addr <= `CBSC_RESET_VEC;
      end else if (i_ce) begin // stopped bus clock freezes state
         state_reg <= state_next;
         resume_reg <= resume_next;
         op_reg <= op_next;
         after_reg <= after_next;
         strobe_reg <= strobe_next;
         o_addr_strobe_n <= ~strobe_next;
         // pulses default low
         o_vector_valid <= 1'b0;
         o_locked_wr_done <= 1'b0;
         o_soft_init_done <= 1'b0;
         // cache engine asked to work while waiting
         o_cache_wb_req <= (state_next == ST_CWB);
         o_cache_inval_req <= (state_next == ST_CWB);
         o_shutdown <= (state_next == ST_SHUT);
         // clock stops only once grant is done and buffers drain
         if (state_reg == ST_GNT && !i_ext_write_buf_empty_n)
            o_int_clk_stopped <= 1'b1;
         else if (state_next != ST_GNT)
            o_int_clk_stopped <= 1'b0;
         // drive the bus for the cycle entered
         o_bus_oe <= 1'b1;
         o_lock_n <= 1'b1;
         o_byte_enables_n <= `CBSC_BE_IDLE;
         o_addr <= `CBSC_ADDR_ZERO;
         o_dc_n <= 1'b0;
         o_mio_n <= 1'b0;
         o_wr_n <= 1'b0;
         case (state_next)
            ST_HOLD: begin
               o_bus_oe <= 1'b0; // float, lock included
               o_addr_strobe_n <= 1'b1;
            end
            ST_LKWR: begin
               o_lock_n <= 1'b0;
               o_mio_n <= 1'b1;
               o_dc_n <= 1'b1;
               o_wr_n <= 1'b1;
               o_byte_enables_n <= 8'h00;
            end
            ST_WBK: begin
               o_lock_n <= 1'b0;
               o_mio_n <= 1'b1;
               o_dc_n <= 1'b1;
               o_wr_n <= 1'b1;
               o_byte_enables_n <= 8'h00;
            end
            ST_ACK1: begin
               o_lock_n <= 1'b0;
               o_byte_enables_n <= `CBSC_BE_ACK1;
            end
            ST_ACK2: begin
               o_lock_n <= 1'b0;
               o_byte_enables_n <= `CBSC_BE_ACK2;
            end
            ST_SPC: begin
               o_wr_n <= 1'b1;
               o_byte_enables_n <= spc_be_n;
               o_addr <= {27'h0000000, spc_a43}; // a4:3 in bits 1:0
            end
            default: o_bus_oe <= (state_next != ST_SHUT);
         endcase
         if (state_reg == ST_ACK2 && burst_ready_n && !bus_backoff_n) begin
            o_vector_valid <= 1'b1;
            o_vector <= i_data_lo;
         end
         if (state_reg == ST_LKWR && burst_ready_n && !bus_backoff_n)
            o_locked_wr_done <= 1'b1;
         if (i_soft_init && (state_reg == ST_SHUT ||
             (state_reg == ST_IDLE && i_instr_boundary))) begin
            o_soft_init_done <= 1'b1;
            o_fetch_addr <= `CBSC_RESET_VEC;
         end
      end
   end
endmodule // cbsc_seq

// ### pkg/cbsc_map.vh
// constants and encodings for the special-cycle bus sequencer
// How it works
// - backoff in locked write aborts, floats all
// - modified hit writeback first, lock held
// - restart write on edge backoff negates
// - irq gives locked dummy then vector read
// - ack reads: control low, address zero, EF/FE
// - special cycle: dc low, mio low, wr high
// - special cycles coded by enables and a4:3
// - flush: writeback, invalidate, then acknowledge
// - writeback_invalidate_instr writeback cycle, then flush cycle; halt cycle
// - triple fault: stop bus, shutdown cycle
// - shutdown left by nmi, init, reset, smi
// - stop clock: grant, then stop once write buffers drain
// - deeper state only if bus clock stops
// - stop request recognised at instruction boundary
// - soft init empties pipes, fetches reset vector
// - soft init recognised at boundary, sampled early
// - backoff always aborts, even with burst ready
`ifndef CBSC_MAP_VH
`define CBSC_MAP_VH
// ------------------------------------------------------------
// byte enables (active low) and address bits 4:3
// ------------------------------------------------------------
`define CBSC_BE_IDLE 8'hff
`define CBSC_BE_ACK1 8'hef
`define CBSC_BE_ACK2 8'hfe
`define CBSC_BE_STOPGNT 8'hfb
`define CBSC_BE_FLUSHACK 8'hef
`define CBSC_BE_WRBACK 8'hf7
`define CBSC_BE_HALT 8'hfb
`define CBSC_BE_FLUSH 8'hfd
`define CBSC_BE_SHUTDN 8'hfe
`define CBSC_A43_STOPGNT 2'h2
`define CBSC_A43_OTHER 2'h0
// ------------------------------------------------------------
// addresses and request codes
// ------------------------------------------------------------
`define CBSC_ADDR_ZERO 29'h00000000
`define CBSC_RESET_VEC 32'hfffffff0
`define CBSC_OP_NONE 3'h0
`define CBSC_OP_STOPGNT 3'h1
`define CBSC_OP_FLUSHACK 3'h2
`define CBSC_OP_WRBACK 3'h3
`define CBSC_OP_HALT 3'h4
`define CBSC_OP_FLUSH 3'h5
`define CBSC_OP_SHUTDN 3'h6
`endif

// ### hw/cbsc_decode.v
// special-cycle encoder: request code to byte enables and a4:3
`timescale 1ns/1ps
`include "cbsc_map.vh"
module cbsc_decode (
   input wire [2:0] i_op,
   output reg [7:0] o_be_n,
   output reg [1:0] o_a43
);
   // ------------------------------------------------------------
   // pure lookup
   // ------------------------------------------------------------
   always @* begin
      o_a43 = `CBSC_A43_OTHER;
      case (i_op)
         `CBSC_OP_STOPGNT: begin
            o_be_n = `CBSC_BE_STOPGNT;
            o_a43 = `CBSC_A43_STOPGNT;
         end
         `CBSC_OP_FLUSHACK: o_be_n = `CBSC_BE_FLUSHACK;
         `CBSC_OP_WRBACK: o_be_n = `CBSC_BE_WRBACK;
         `CBSC_OP_HALT: o_be_n = `CBSC_BE_HALT;
         `CBSC_OP_FLUSH: o_be_n = `CBSC_BE_FLUSH;
         `CBSC_OP_SHUTDN: o_be_n = `CBSC_BE_SHUTDN;
         default: o_be_n = `CBSC_BE_IDLE;
      endcase
   end
endmodule // cbsc_decode

// ### testbench/cbsc_seq_props.sv
// checker for the special-cycle bus sequencer ports
`timescale 1ns/1ps
module cbsc_seq_props (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_ce,
   input wire i_bus_backoff_n,
   input wire i_nmi,
   input wire i_stop_clock_req_n,
   input wire i_ext_write_buf_empty_n,
   input wire o_addr_strobe_n,
   input wire o_lock_n,
   input wire o_bus_oe,
   input wire o_dc_n,
   input wire o_mio_n,
   input wire o_wr_n,
   input wire [7:0] o_byte_enables_n,
   input wire [28:0] o_addr,
   input wire o_int_clk_stopped,
   input wire o_shutdown
);
   // ----------------------------------------
   // helper: a locked cycle was backed off
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic pend_reg; // cleared by the restart strobe
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) pend_reg <= 1'b0;
      else if (!i_bus_backoff_n && !o_lock_n && o_bus_oe) pend_reg <= 1'b1;
      else if (!o_addr_strobe_n) pend_reg <= 1'b0;
   end
   // ----------------------------------------
   // acknowledge pair steps
   // ----------------------------------------
   sequence ack_first;
      !o_addr_strobe_n && !o_wr_n && !o_dc_n && o_byte_enables_n == 8'hef;
   endsequence
   sequence ack_second;
      !o_addr_strobe_n && !o_wr_n && !o_dc_n && o_byte_enables_n == 8'hfe;
   endsequence
   a_backoff_float: assert property (
      !i_bus_backoff_n && !o_lock_n && o_bus_oe |=> !o_bus_oe)
      else $error("bus still driven after backoff");
   a_hold_no_strobe: assert property (
      !i_bus_backoff_n |=> o_addr_strobe_n)
      else $error("strobe during backoff");
   a_restart_edge: assert property (
      $rose(i_bus_backoff_n) && pend_reg |=> !o_addr_strobe_n && !o_lock_n)
      else $error("late restart");
   a_ack_order: assert property (
      ack_first |-> ##[1:60] ack_second)
      else $error("second acknowledge read missing");
   a_ack_ctrl: assert property (
      !o_addr_strobe_n && !o_wr_n && !o_dc_n
      |-> !o_mio_n && o_addr == 29'h0 && !o_lock_n)
      else $error("bad acknowledge read");
   a_special_ctrl: assert property (
      !o_addr_strobe_n && o_wr_n && !o_dc_n
      |-> !o_mio_n && o_addr[28:2] == 27'h0)
      else $error("bad special cycle");
   a_clk_stop_cause: assert property (
      $rose(o_int_clk_stopped) |-> !$past(i_ext_write_buf_empty_n))
      else $error("clock stopped early");
   a_stop_leave: assert property (
      o_int_clk_stopped && i_stop_clock_req_n && i_ce
      |-> ##[1:3] !o_int_clk_stopped)
      else $error("stuck stopped");
   a_shutdown_exit: assert property (
      o_shutdown && i_nmi |-> ##[1:3] !o_shutdown)
      else $error("stuck in shutdown");
endmodule // cbsc_seq_props
bind cbsc_seq cbsc_seq_props u_cbsc_seq_props (.i_clk_sys(i_clk_sys),
   .i_rst(i_rst), .i_ce(i_ce),
   .i_bus_backoff_n(i_bus_backoff_n), .i_nmi(i_nmi),
   .i_stop_clock_req_n(i_stop_clock_req_n),
   .i_ext_write_buf_empty_n(i_ext_write_buf_empty_n),
   .o_addr_strobe_n(o_addr_strobe_n), .o_lock_n(o_lock_n),
   .o_bus_oe(o_bus_oe), .o_dc_n(o_dc_n), .o_mio_n(o_mio_n), .o_wr_n(o_wr_n),
   .o_byte_enables_n(o_byte_enables_n), .o_addr(o_addr),
   .o_int_clk_stopped(o_int_clk_stopped), .o_shutdown(o_shutdown));

// ### testbench/cbsc_chipset_model.sv
// system logic model: answers each bus cycle with burst ready
`timescale 1ns/1ps
module cbsc_chipset_model #(
   parameter logic [7:0] VEC = 8'h5a
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_addr_strobe_n,
   input wire logic i_slow,
   output logic o_burst_ready_n,
   output logic [7:0] o_data_lo
);
   logic busy_reg;
   logic [2:0] cnt_reg; // wait states left
   // data toggles off ready so a stale byte never looks valid
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 3'h0;
         o_burst_ready_n <= 1'b1;
         o_data_lo <= 8'h00;
      end else begin
         o_burst_ready_n <= 1'b1;
         o_data_lo <= ~o_data_lo;
         if (!i_addr_strobe_n) begin
            busy_reg <= 1'b1;
            cnt_reg <= i_slow ? 3'h3 : 3'h0;
         end else if (busy_reg && cnt_reg == 3'h0) begin
            busy_reg <= 1'b0;
            o_burst_ready_n <= 1'b0;
            o_data_lo <= VEC;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 3'h1;
         end
      end
   end
endmodule // cbsc_chipset_model

// ### testbench/cbsc_seq_tb.sv
// self-checking bench for the special-cycle bus sequencer
`timescale 1ns/1ps
`include "cbsc_map.vh"
module cbsc_seq_tb;
   logic clk = 0, rst = 1, bus_backoff_n_n = 1, irq = 0, stp_n = 1, ext_write_buf_empty_n_n = 1;
   logic nmi = 0, sinit = 0, fl_n = 1, bnd = 0, lwr = 0, wbd = 0;
   logic halt_instr = 0, tf = 0, slow = 0, mh = 0, wbi = 0, ce = 1;
   wire rdy_n, ads_n, lock_n, oe, dc_n, mio_n, wr_n, wbq, ivq, vv, lwd;
   wire stopd, sdn, sid;
   wire [7:0] dlo, be, vec;
   wire [28:0] ad;
   wire [31:0] fa;
   int fail_count = 0, cmp_count = 0, i;
   cbsc_seq u_cbsc_seq (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
      .i_bus_backoff_n(bus_backoff_n_n), .i_burst_ready_n(rdy_n),
      .i_maskable_irq_req(irq), .i_stop_clock_req_n(stp_n),
      .i_ext_write_buf_empty_n(ext_write_buf_empty_n_n), .i_sys_mgmt_irq_n(1'b1),
      .i_nmi(nmi), .i_soft_init(sinit), .i_cache_flush_n(fl_n),
      .i_instr_boundary(bnd), .i_locked_wr_req(lwr), .i_modified_hit(mh),
      .i_cache_wb_done(wbd), .i_writeback_invalidate_instr(wbi),
      .i_invalidate_instr(1'b0), .i_halt_instr(halt_instr), .i_triple_fault(tf),
      .i_data_lo(dlo), .o_addr_strobe_n(ads_n), .o_lock_n(lock_n),
      .o_bus_oe(oe), .o_dc_n(dc_n), .o_mio_n(mio_n), .o_wr_n(wr_n),
      .o_byte_enables_n(be), .o_addr(ad), .o_cache_wb_req(wbq),
      .o_cache_inval_req(ivq), .o_vector_valid(vv), .o_vector(vec),
      .o_locked_wr_done(lwd), .o_int_clk_stopped(stopd),
      .o_shutdown(sdn), .o_soft_init_done(sid), .o_fetch_addr(fa));
   cbsc_chipset_model u_cbsc_chipset_model (.i_clk_sys(clk), .i_rst(rst),
      .i_addr_strobe_n(ads_n), .i_slow(slow), .o_burst_ready_n(rdy_n),
      .o_data_lo(dlo));
   initial forever #2 clk = ~clk;
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task wait_ads; // bounded wait for a strobe
      #1; // never read the strobe in the step of its launching edge
      for (i = 0; i < 60 && ads_n !== 1'b0; i++) begin
         @(posedge clk); #1;
      end
   endtask
   task end_cycle; // let ready close the cycle
      for (i = 0; i < 60 && rdy_n !== 1'b0; i++) begin
         @(posedge clk); #1;
      end
      @(posedge clk); // a follow-on strobe launches at this edge
   endtask
   task special(input logic [7:0] ebe, input logic [1:0] ea);
      wait_ads;
      chk("strobe", ads_n, 0);
      chk("enables", be, ebe);
      chk("addr", ad, {27'h0, ea});
      chk("ctrl", {dc_n, mio_n, wr_n}, 3'b001);
      end_cycle;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task s_halt;
      @(posedge clk); halt_instr <= 1;
      @(posedge clk); halt_instr <= 0;
      special(`CBSC_BE_HALT, `CBSC_A43_OTHER);
   endtask
   task s_flush; // acknowledge only after cache work ends
      @(posedge clk); fl_n <= 0;
      @(posedge clk); fl_n <= 1;
      repeat (3) @(posedge clk); #1;
      chk("strobe early", ads_n, 1);
      chk("cache req", {wbq, ivq}, 2'b11);
      @(posedge clk); wbd <= 1;
      @(posedge clk); wbd <= 0;
      special(`CBSC_BE_FLUSHACK, `CBSC_A43_OTHER);
   endtask
   task s_writeback_invalidate_instr; // writeback special after cache work, then flush
      @(posedge clk); wbi <= 1;
      @(posedge clk); wbi <= 0;
      @(posedge clk); wbd <= 1;
      @(posedge clk); wbd <= 0;
      special(`CBSC_BE_WRBACK, `CBSC_A43_OTHER);
      special(`CBSC_BE_FLUSH, `CBSC_A43_OTHER);
   endtask
   task s_irq; // slow ready on both reads
      @(posedge clk); irq <= 1; bnd <= 1; slow <= 1;
      @(posedge clk); bnd <= 0;
      wait_ads;
      chk("ack1 be", be, 8'hef);
      chk("ack1 ctl", {dc_n, mio_n, wr_n, lock_n}, 4'h0);
      chk("ack1 addr", ad, 29'h0);
      end_cycle;
      wait_ads;
      chk("ack2 be", be, 8'hfe);
      chk("ack2 ctl", {dc_n, mio_n, wr_n, lock_n}, 4'h0);
      chk("ack2 addr", ad, 29'h0);
      for (i = 0; i < 60 && vv !== 1'b1; i++) begin
         @(posedge clk); #1;
      end
      chk("vector", vec, 8'h5a);
      @(posedge clk); irq <= 0; slow <= 0; // held through the pair
      repeat (2) @(posedge clk);
   endtask
   task s_stop; // grant, stop after buffer empty, then resume
      @(posedge clk); stp_n <= 0; bnd <= 1;
      @(posedge clk); bnd <= 0;
      special(`CBSC_BE_STOPGNT, `CBSC_A43_STOPGNT);
      #1 chk("stopped early", stopd, 0);
      @(posedge clk); ext_write_buf_empty_n_n <= 0;
      repeat (3) @(posedge clk); #1;
      chk("stopped", stopd, 1);
      @(posedge clk); ce <= 0; stp_n <= 1; ext_write_buf_empty_n_n <= 1;
      repeat (3) @(posedge clk); #1;
      chk("frozen", stopd, 1);
      @(posedge clk); ce <= 1;
      repeat (3) @(posedge clk); #1;
      chk("resumed", stopd, 0);
      s_halt; // normal bus work again
   endtask
   task s_shut;
      @(posedge clk); tf <= 1;
      @(posedge clk); tf <= 0;
      special(`CBSC_BE_SHUTDN, `CBSC_A43_OTHER);
      #1 chk("shutdown", sdn, 1);
      @(posedge clk); nmi <= 1;
      repeat (2) @(posedge clk); nmi <= 0;
      repeat (2) @(posedge clk); #1;
      chk("shutdown left", sdn, 0);
   endtask
   task s_init;
      @(posedge clk); sinit <= 1; bnd <= 1;
      @(posedge clk); sinit <= 0; bnd <= 0; // one synchronous clock
      #1;
      for (i = 0; i < 20 && sid !== 1'b1; i++) begin
         @(posedge clk); #1;
      end
      chk("init done", sid, 1);
      chk("fetch", fa, `CBSC_RESET_VEC);
   endtask
   task s_bus_backoff_n; // ready during backoff must be ignored
      @(posedge clk); lwr <= 1; slow <= 1;
      @(posedge clk); lwr <= 0;
      wait_ads;
      chk("locked", {lock_n, wr_n}, 2'b01);
      @(posedge clk); bus_backoff_n_n <= 0;
      @(posedge clk); #1;
      chk("floated", oe, 0);
      repeat (6) @(posedge clk); // locked data left alone
      bus_backoff_n_n <= 1;
      @(posedge clk); #1;
      chk("restart", {ads_n, lock_n, oe}, 3'b001);
      for (i = 0; i < 60 && lwd !== 1'b1; i++) begin
         @(posedge clk); #1;
      end
      chk("write done", lwd, 1);
   endtask
   task s_bus_backoff_n_hit; // backoff with ready; inquire hits a modified line
      @(posedge clk); lwr <= 1; slow <= 0;
      @(posedge clk); lwr <= 0;
      wait_ads;
      @(posedge clk);
      @(posedge clk); bus_backoff_n_n <= 0;
      @(posedge clk); mh <= 1; // inquire after the backoff edge
      #1 chk("abort on ready", {oe, lwd}, 2'b00);
      repeat (3) @(posedge clk);
      bus_backoff_n_n <= 1;
      @(posedge clk); #1;
      chk("wb first", {ads_n, lock_n, mio_n}, 3'b001);
      @(posedge clk); mh <= 0;
      end_cycle;
      #1 chk("no early done", lwd, 0);
      wait_ads;
      chk("restart", {ads_n, lock_n}, 2'b00);
      for (i = 0; i < 60 && lwd !== 1'b1; i++) begin
         @(posedge clk); #1;
      end
      chk("write done", lwd, 1);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      s_halt;
      s_flush;
      s_writeback_invalidate_instr;
      s_irq;
      s_stop;
      s_shut;
      s_init;
      s_bus_backoff_n;
      s_bus_backoff_n_hit;
      give_verdict;
   end
   initial begin // watchdog, far beyond the expected run
      #100000;
      fail_count++;
      give_verdict;
   end
endmodule // cbsc_seq_tb
